// ### rtl/pll_clock_and_sleep_gating.sv
// PLL lock control, system clock selection and sleep clock gating
//
// Our own choices: the address map and the Wishbone interface to the registers.
`default_nettype none
module pll_clock_and_sleep_gating
  import clk_ctrl_pkg::*;
#(
  parameter int lock_count_w = 13
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mosc_tick,
  input wire logic wfi_req,
  input wire logic deep_sleep_en,
  input wire logic wake_irq,
  output logic pll_lock_irq,
  output logic pll_power_down,
  output logic [31:0] pll_translation,
  output sys_clk_t sys_clk,
  output logic core_clk_en,
  output gate_set_t periph_clk_en,
  output logic iosc_power_up,
  output logic mosc_power_down
);

  // ***************************************************
  // helpers
  // ***************************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
    input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic [31:0] xlate(input logic [3:0] crystal_select);
    logic [31:0] r;
    r = 32'h0;
    r[3:0] = crystal_select;
    r[15:8] = 8'(xlate_base - {2'b00, crystal_select, 2'b00});
    return r;
  endfunction

  // ***************************************************
  // registers
  // ***************************************************
  logic [31:0] run_clock_config;
  logic [31:0] run_clock_config_ext;
  logic [31:0] deepsleep_clock_config;
  gate_set_t run_gating;
  gate_set_t sleep_gating;
  gate_set_t deepsleep_gating;
  logic irq_mask_control;
  logic pll_lock_raw_flag;
  logic lock_ok;
  logic [lock_count_w-1:0] lock_cnt;
  logic locking;
  logic prev_pd;
  power_mode_t mode;
  power_mode_t next_mode;
  sys_clk_t saved_clk;
  logic saved_pll_on;

  logic wr;
  logic rd_sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [3:0] new_crystal_select;
  logic crystal_select_change;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd_sel = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // ***************************************************
  // effective configuration
  // ***************************************************
  logic use_ext;
  logic eff_pd;
  logic eff_bypass;
  logic eff_div_use;
  logic [5:0] eff_div;
  logic [2:0] eff_osc;
  logic pd_req;

  always_comb
  begin
    use_ext = run_clock_config_ext[ext_override_bit];
    eff_div_use = run_clock_config[divider_use_bit];
    if (use_ext)
    begin
      eff_pd = run_clock_config_ext[pll_power_down_bit];
      eff_bypass = run_clock_config_ext[bypass_bit];
      eff_div = run_clock_config_ext[system_divider_lo +: 6];
      eff_osc = run_clock_config_ext[ext_osc_lo +: 3];
    end
    else
    begin
      eff_pd = run_clock_config[pll_power_down_bit];
      eff_bypass = run_clock_config[bypass_bit];
      eff_div = {2'b00, run_clock_config[system_divider_lo +: 4]};
      eff_osc = {1'b0, run_clock_config[osc_lo +: 2]};
    end
    pd_req = eff_pd || (mode != mode_run && mode != mode_sleep
      && saved_pll_on);
  end

  // ***************************************************
  // bus slave
  // ***************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= rd_sel;
  end

  always_comb
  begin
    case (wb_adr_i)
      off_raw_irq_status: rdat = 32'(pll_lock_raw_flag) << lock_flag_bit;
      off_irq_mask_control: rdat = 32'(irq_mask_control) << lock_flag_bit;
      off_masked_irq:
        rdat = 32'(pll_lock_raw_flag & irq_mask_control) << lock_flag_bit;
      off_run_clock_config: rdat = run_clock_config;
      off_pll_translation: rdat = pll_translation;
      off_run_clock_config_ext: rdat = run_clock_config_ext;
      off_run_gating: rdat = run_gating.g0;
      off_run_gating + 12'h004: rdat = run_gating.g1;
      off_run_gating + 12'h008: rdat = run_gating.g2;
      off_sleep_gating: rdat = sleep_gating.g0;
      off_sleep_gating + 12'h004: rdat = sleep_gating.g1;
      off_sleep_gating + 12'h008: rdat = sleep_gating.g2;
      off_deepsleep_gating: rdat = deepsleep_gating.g0;
      off_deepsleep_gating + 12'h004: rdat = deepsleep_gating.g1;
      off_deepsleep_gating + 12'h008: rdat = deepsleep_gating.g2;
      off_deepsleep_clock_config: rdat = deepsleep_clock_config;
      default: rdat = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      wb_dat_o <= 32'h0;
    else if (rd_sel && !wb_we_i)
      wb_dat_o <= rdat;
  end

  // ***************************************************
  // configuration writes
  // ***************************************************
  always_comb
  begin
    wdat = merge(run_clock_config, wb_dat_i, wb_sel_i);
    new_crystal_select = wdat[crystal_lo +: 4];
    // same value written again is no change
    crystal_select_change = wr && wb_adr_i == off_run_clock_config
      && new_crystal_select != run_clock_config[crystal_lo +: 4];
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_clock_config <= rst_run_clock_config;
      run_clock_config_ext <= rst_run_clock_config_ext;
      deepsleep_clock_config <= rst_deepsleep_clock_config;
      irq_mask_control <= 1'b0;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        off_run_clock_config: run_clock_config <= wdat;
        off_run_clock_config_ext: run_clock_config_ext <=
          merge(run_clock_config_ext, wb_dat_i, wb_sel_i);
        off_deepsleep_clock_config: deepsleep_clock_config <=
          merge(deepsleep_clock_config, wb_dat_i, wb_sel_i);
        off_irq_mask_control: irq_mask_control <= wb_sel_i[0] ?
          wb_dat_i[lock_flag_bit] : irq_mask_control;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_gating <= {rst_gating, rst_gating, rst_gating0};
      sleep_gating <= {rst_gating, rst_gating, rst_gating0};
      deepsleep_gating <= {rst_gating, rst_gating, rst_gating0};
    end
    else if (wr)
    begin
      case (wb_adr_i)
        off_run_gating: run_gating.g0 <= merge(run_gating.g0, wb_dat_i, wb_sel_i);
        off_run_gating + 12'h004:
          run_gating.g1 <= merge(run_gating.g1, wb_dat_i, wb_sel_i);
        off_run_gating + 12'h008:
          run_gating.g2 <= merge(run_gating.g2, wb_dat_i, wb_sel_i);
        off_sleep_gating:
          sleep_gating.g0 <= merge(sleep_gating.g0, wb_dat_i, wb_sel_i);
        off_sleep_gating + 12'h004:
          sleep_gating.g1 <= merge(sleep_gating.g1, wb_dat_i, wb_sel_i);
        off_sleep_gating + 12'h008:
          sleep_gating.g2 <= merge(sleep_gating.g2, wb_dat_i, wb_sel_i);
        off_deepsleep_gating:
          deepsleep_gating.g0 <= merge(deepsleep_gating.g0, wb_dat_i, wb_sel_i);
        off_deepsleep_gating + 12'h004:
          deepsleep_gating.g1 <= merge(deepsleep_gating.g1, wb_dat_i, wb_sel_i);
        off_deepsleep_gating + 12'h008:
          deepsleep_gating.g2 <= merge(deepsleep_gating.g2, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // ***************************************************
  // translation and lock timing
  // ***************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pll_translation <= xlate(rst_run_clock_config[crystal_lo +: 4]);
    else if (crystal_select_change)
      pll_translation <= xlate(new_crystal_select);
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pll_power_down <= 1'b1;
      prev_pd <= 1'b1;
    end
    else
    begin
      pll_power_down <= pd_req;
      prev_pd <= pd_req;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lock_cnt <= '0;
      locking <= 1'b0;
      lock_ok <= 1'b0;
    end
    else if (crystal_select_change || (prev_pd && !pd_req))
    begin
      lock_cnt <= lock_count_w'(lock_start);
      locking <= 1'b1;
      lock_ok <= 1'b0;
    end
    else if (pd_req)
    begin
      locking <= 1'b0;
      lock_ok <= 1'b0;
    end
    else if (locking && mosc_tick)
    begin
      if (lock_cnt == '0)
      begin
        locking <= 1'b0;
        lock_ok <= 1'b1;
      end
      else
        lock_cnt <= lock_cnt - 1'b1;
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pll_lock_raw_flag <= 1'b0;
    else if (locking && mosc_tick && lock_cnt == '0 && !pd_req)
      pll_lock_raw_flag <= 1'b1;
    else if (wr && wb_adr_i == off_masked_irq && wb_sel_i[0]
      && wb_dat_i[lock_flag_bit])
      pll_lock_raw_flag <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      pll_lock_irq <= 1'b0;
    else
      pll_lock_irq <= pll_lock_raw_flag && irq_mask_control;
  end

  // ***************************************************
  // power mode sequencing
  // ***************************************************
  always_comb
  begin
    case (mode)
      mode_run: next_mode = !wfi_req ? mode_run :
        (deep_sleep_en ? mode_deep : mode_sleep);
      mode_sleep: next_mode = wake_irq ? mode_run : mode_sleep;
      mode_deep: next_mode = wake_irq ? mode_restore : mode_deep;
      mode_restore: next_mode = mode_run;
      default: next_mode = mode_run;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode <= mode_run;
      saved_clk <= '0;
      saved_pll_on <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      if (mode == mode_run && next_mode == mode_deep)
      begin
        saved_clk <= sys_clk;
        saved_pll_on <= !eff_pd;
      end
      else if (mode == mode_restore)
        saved_pll_on <= 1'b0;
    end
  end

  // ***************************************************
  // clock selection and gating
  // ***************************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sys_clk <= '0;
      core_clk_en <= 1'b1;
      periph_clk_en <= {rst_gating, rst_gating, rst_gating0};
      iosc_power_up <= 1'b1;
      mosc_power_down <= 1'b0;
    end
    else
    begin
      case (mode)
        mode_run:
        begin
          sys_clk.osc <= eff_osc;
          // pll held off until lock met
          sys_clk.use_pll <= !eff_bypass && !eff_pd && lock_ok;
          sys_clk.div_en <= eff_div_use;
          sys_clk.div <= eff_div;
          core_clk_en <= 1'b1;
          periph_clk_en <= run_gating;
          iosc_power_up <= 1'b1;
          mosc_power_down <= 1'b0;
        end
        mode_sleep:
        begin
          core_clk_en <= 1'b0;
          periph_clk_en <= run_clock_config[auto_gate_bit] ?
            sleep_gating : run_gating;
        end
        mode_deep:
        begin
          core_clk_en <= 1'b0;
          periph_clk_en <= run_clock_config[auto_gate_bit] ?
            deepsleep_gating : run_gating;
          sys_clk.osc <= deepsleep_clock_config[ds_osc_lo +: 3];
          if (deepsleep_clock_config[ds_osc_lo +: 3] != osc_main)
          begin
            iosc_power_up <= 1'b1;
            mosc_power_down <= 1'b1;
          end
          if (saved_pll_on)
          begin
            sys_clk.use_pll <= 1'b0;
            sys_clk.div_en <= 1'b1;
            sys_clk.div <= use_ext ? ds_div_64 : ds_div_16;
          end
        end
        mode_restore:
        begin
          sys_clk <= saved_clk;
          sys_clk.use_pll <= saved_clk.use_pll && lock_ok;
          iosc_power_up <= 1'b1;
          mosc_power_down <= 1'b0;
        end
        default: core_clk_en <= 1'b1;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### rtl/clk_ctrl_pkg.sv
// constants, field layouts and types of the clock and sleep controller
// What this block does
// - PLL powers up disabled and stays off until software enables it
// - new crystal value is translated; translation shown in a read-only register
// - writing the same crystal value is no change and starts no relock
// - PLL leaving power-down for normal mode starts a relock
// - each relock loads oscillator-clocked down counter; PLL unusable until expiry
// - PLL cannot become system clock before the lock counter expires
// - enable and select PLL together: stay on oscillator until lock, then switch
// - lock sets raw lock flag in raw status and offers a lock interrupt
// - normal mode drives PLL output; power-down disables it
// - run mode clocks core and peripherals whose run gating bits are set
// - sleep stops core and memory; peripherals per sleep or run gating
// - deep-sleep stops core and memory; peripherals per deep-sleep or run gating
// - deep-sleep runs from main oscillator unless an internal one is chosen
// - running PLL is powered down in deep-sleep; divider forced to 16 or 64
// - deep-sleep exit restores clock source and divider before clocks return
// - sleep only on code request; enabled interrupt returns to run
// - wait-for-interrupt enters deep-sleep if deep-sleep enable set, else sleep
// - power-down, bypass, divider and oscillator come from extended register while override bit set, else first
// - bypass set with divider unused gives raw oscillator as system clock
// - divider-use applies system divider; clearing power-down enables PLL
// - extended register fields take precedence while it is in use
// - masked status shows lock interrupt after mask; writing one clears it
package clk_ctrl_pkg;
  localparam logic [11:0] off_raw_irq_status = 12'h050;
  localparam logic [11:0] off_irq_mask_control = 12'h054;
  localparam logic [11:0] off_masked_irq = 12'h058;
  localparam logic [11:0] off_run_clock_config = 12'h060;
  localparam logic [11:0] off_pll_translation = 12'h064;
  localparam logic [11:0] off_run_clock_config_ext = 12'h070;
  localparam logic [11:0] off_run_gating = 12'h100;
  localparam logic [11:0] off_sleep_gating = 12'h110;
  localparam logic [11:0] off_deepsleep_gating = 12'h120;
  localparam logic [11:0] off_deepsleep_clock_config = 12'h144;
  localparam logic [31:0] rst_run_clock_config = 32'h0780_3ad1;
  localparam logic [31:0] rst_run_clock_config_ext = 32'h0780_2810;
  localparam logic [31:0] rst_gating0 = 32'h0000_0040;
  localparam logic [31:0] rst_gating = 32'h0000_0000;
  localparam logic [31:0] rst_deepsleep_clock_config = 32'h0780_0000;
  // field positions in the first configuration register
  localparam int auto_gate_bit = 27;
  localparam int system_divider_lo = 23;
  localparam int divider_use_bit = 22;
  localparam int pll_power_down_bit = 13;
  localparam int bypass_bit = 11;
  localparam int crystal_lo = 6;
  localparam int osc_lo = 4;
  // field positions in the extended register
  localparam int ext_override_bit = 31;
  localparam int ext_osc_lo = 4;
  // deep-sleep oscillator field
  localparam int ds_osc_lo = 4;
  localparam int lock_flag_bit = 6;
  localparam logic [12:0] lock_start = 13'h1200;
  localparam logic [5:0] ds_div_16 = 6'h0f;
  localparam logic [5:0] ds_div_64 = 6'h3f;
  localparam logic [2:0] osc_main = 3'h0;
  localparam logic [7:0] xlate_base = 8'hc8;
  typedef enum logic [1:0] {
    mode_run = 2'b00,
    mode_sleep = 2'b01,
    mode_deep = 2'b10,
    mode_restore = 2'b11
  } power_mode_t;
  typedef struct packed {
    logic [31:0] g2;
    logic [31:0] g1;
    logic [31:0] g0;
  } gate_set_t;
  typedef struct packed {
    logic [2:0] osc;
    logic use_pll;
    logic div_en;
    logic [5:0] div;
  } sys_clk_t;
endpackage

// ### dv/clk_ctrl_chk.sv
// port assertions for the clock and sleep controller
`default_nettype none
module clk_ctrl_chk
  import clk_ctrl_pkg::*;
#(
  parameter int lock_count_w = 13
)(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic mosc_tick,
  input wire logic wfi_req,
  input wire logic deep_sleep_en,
  input wire logic wake_irq,
  input wire logic pll_power_down,
  input wire logic [31:0] pll_translation,
  input wire sys_clk_t sys_clk,
  input wire logic core_clk_en,
  input wire logic iosc_power_up,
  input wire logic mosc_power_down
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] ticks;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);
  // ***************************************
  // oscillator ticks since the last relock
  // ***************************************
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      ticks <= '0;
    else if ($fell(pll_power_down) || $changed(pll_translation))
      ticks <= '0;
    else if (mosc_tick && ticks != 14'h3fff)
      ticks <= ticks + 14'h0001;
  end
  sequence go_sleep;
    wfi_req && core_clk_en && !wake_irq;
  endsequence
  sequence wake_up;
    !core_clk_en && wake_irq;
  endsequence
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  pll_quiet_a: assert property (
    pll_power_down ##1 pll_power_down |-> !sys_clk.use_pll)
    else $error("powered down pll selected");
  lock_wait_a: assert property (
    sys_clk.use_pll |-> ticks >= 14'h11f0)
    else $error("pll selected before lock time");
  sleep_entry_a: assert property (
    go_sleep |-> ##[1:3] !core_clk_en)
    else $error("core clock kept after wait request");
  deep_entry_a: assert property (
    go_sleep ##0 deep_sleep_en |-> ##[1:3] (pll_power_down && !core_clk_en))
    else $error("pll not powered down in deep sleep");
  by_code_a: assert property (
    $fell(core_clk_en) |-> $past(wfi_req) || $past(wfi_req, 2)
      || $past(wfi_req, 3))
    else $error("core clock stopped without request");
  wake_run_a: assert property (wake_up |-> ##[1:4] core_clk_en)
    else $error("no return to run on wake event");
  restore_first_a: assert property (
    $rose(core_clk_en) |-> $stable(sys_clk))
    else $error("clocks enabled while system clock changes");
  mosc_off_a: assert property (
    mosc_power_down |-> iosc_power_up && !core_clk_en)
    else $error("main oscillator off outside deep sleep");
  pd_by_sw_a: assert property (
    $fell(pll_power_down) |-> $past(wb_ack_o) || $past(wb_ack_o, 2)
      || !$past(core_clk_en) || !$past(core_clk_en, 2))
    else $error("pll enabled without software write");
endmodule
`default_nettype wire

// ### dv/tb_top.sv
// testbench for the clock and sleep controller
`default_nettype none
module tb_top;
  import clk_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int lock_count_w = 13;
  localparam logic [31:0] cfg_a = 32'h01c0_0180;
  localparam logic [31:0] cfg_b = 32'h01c0_01c0;
  localparam logic [31:0] auto = 32'h0800_0000;
  logic core_clk, resetn, cyc, stb, we, mosc_tick, wfi, ds_en, wake;
  logic ack, pd, irq, cen, iosc_up, mosc_dn;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, dout, rdat, trans;
  sys_clk_t sc;
  gate_set_t gates;
  int n_fail, samples_checked;
  pll_clock_and_sleep_gating #(.lock_count_w(lock_count_w))
    i_pll_clock_and_sleep_gating (.core_clk(core_clk), .resetn(resetn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack),
    .mosc_tick(mosc_tick), .wfi_req(wfi), .deep_sleep_en(ds_en),
    .wake_irq(wake), .pll_lock_irq(irq), .pll_power_down(pd),
    .pll_translation(trans), .sys_clk(sc), .core_clk_en(cen),
    .periph_clk_en(gates), .iosc_power_up(iosc_up),
    .mosc_power_down(mosc_dn));
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // ***************************************
  // bus and check helpers
  // ***************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1)
      @(posedge core_clk);
    rdat = dout;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(rdat, exp);
  endtask
  function automatic logic [31:0] xl(input logic [3:0] x);
    return {16'h0, xlate_base - {2'b00, x, 2'b00}, 4'h0, x};
  endfunction
  task wait_lock;
    int n;
    n = 0;
    mosc_tick <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (irq !== 1'b1);
    mosc_tick <= 1'b0;
    chk({31'h0, n >= 32'h1201 && n <= 32'h1203}, 32'h1);
    wr(off_masked_irq, 32'h40);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task go_wfi(input logic deep);
    ds_en <= deep;
    @(posedge core_clk);
    wfi <= 1'b1;
    @(posedge core_clk);
    wfi <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task go_wake;
    wake <= 1'b1;
    @(posedge core_clk);
    wake <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  // ***************************************
  // scenarios
  // ***************************************
  task t_reset;
    logic [11:0] ra[9];
    logic [31:0] rv[9];
    ra = '{off_run_clock_config, off_run_clock_config_ext, off_run_gating,
      12'h104, off_sleep_gating, off_deepsleep_gating,
      off_deepsleep_clock_config, off_irq_mask_control, 12'h0fc};
    rv = '{rst_run_clock_config, rst_run_clock_config_ext, rst_gating0,
      rst_gating, rst_gating0, rst_gating0, rst_deepsleep_clock_config,
      32'h0, 32'h0};
    chk({31'h0, pd}, 32'h1);
    chk({21'h0, sc}, {21'h0, 3'h1, 2'b00, 6'h0f});
    chk({16'h0, trans[15:0]}, xl(4'hb));
    chk(gates.g0, rst_gating0);
    for (int i = 0; i < 9; i++)
      rd(ra[i], rv[i]);
    wr(12'h0fc, 32'hffff_ffff);
    rd(12'h0fc, 32'h0);
  endtask
  task t_lock;
    wr(off_irq_mask_control, 32'h40);
    wr(off_run_clock_config, cfg_a);
    repeat (3) @(posedge core_clk);
    chk({16'h0, trans[15:0]}, xl(4'h6));
    chk({31'h0, sc.use_pll}, 32'h0);
    chk({31'h0, pd}, 32'h0);
    mosc_tick <= 1'b1;
    repeat (32'h1100) @(posedge core_clk);
    mosc_tick <= 1'b0;
    rd(off_raw_irq_status, 32'h0);
    chk({31'h0, sc.use_pll}, 32'h0);
    mosc_tick <= 1'b1;
    do
      @(posedge core_clk);
    while (irq !== 1'b1);
    mosc_tick <= 1'b0;
    chk({31'h0, sc.use_pll}, 32'h1);
    chk({21'h0, sc}, {21'h0, osc_main, 2'b11, 6'h03});
    rd(off_raw_irq_status, 32'h40);
    rd(off_masked_irq, 32'h40);
    wr(off_irq_mask_control, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq}, 32'h0);
    rd(off_masked_irq, 32'h0);
    wr(off_masked_irq, 32'h40);
    rd(off_raw_irq_status, 32'h0);
    wr(off_irq_mask_control, 32'h40);
    wr(off_run_clock_config, cfg_a);
    repeat (3) @(posedge core_clk);
    chk({31'h0, sc.use_pll}, 32'h1);
    wr(off_run_clock_config, cfg_b);
    repeat (3) @(posedge core_clk);
    chk({16'h0, trans[15:0]}, xl(4'h7));
    chk({31'h0, sc.use_pll}, 32'h0);
    wait_lock;
  endtask
  task t_sleep;
    wr(off_run_gating, 32'h41);
    wr(off_sleep_gating, 32'h05);
    wr(off_run_clock_config, cfg_b | auto);
    repeat (2) @(posedge core_clk);
    chk({31'h0, cen}, 32'h1);
    chk(gates.g0, 32'h41);
    go_wfi(1'b0);
    chk({31'h0, cen}, 32'h0);
    chk(gates.g0, 32'h05);
    chk({31'h0, sc.use_pll}, 32'h1);
    go_wake;
    chk({31'h0, cen}, 32'h1);
    chk(gates.g0, 32'h41);
    wr(off_run_clock_config, cfg_b);
    go_wfi(1'b0);
    chk(gates.g0, 32'h41);
    go_wake;
  endtask
  task t_deep;
    wr(off_deepsleep_gating, 32'h09);
    wr(off_deepsleep_clock_config, 32'h0780_0010);
    wr(off_run_clock_config, cfg_b | auto);
    go_wfi(1'b1);
    chk({31'h0, cen}, 32'h0);
    chk(gates.g0, 32'h09);
    chk({31'h0, pd}, 32'h1);
    chk({26'h0, sc.div}, {26'h0, ds_div_16});
    chk({29'h0, sc.osc}, 32'h1);
    chk({30'h0, iosc_up, mosc_dn}, 32'h3);
    go_wake;
    chk({31'h0, cen}, 32'h1);
    chk({26'h0, sc.div}, 32'h03);
    chk({29'h0, sc.osc}, {29'h0, osc_main});
    wait_lock;
    wr(off_run_clock_config_ext, 32'h8280_0000);
    repeat (2) @(posedge core_clk);
    chk({26'h0, sc.div}, 32'h05);
    wr(off_deepsleep_clock_config, rst_deepsleep_clock_config);
    go_wfi(1'b1);
    chk({26'h0, sc.div}, {26'h0, ds_div_64});
    chk({29'h0, sc.osc, mosc_dn}, {28'h0, osc_main, 1'b0});
    go_wake;
    wr(off_run_clock_config_ext, 32'h0280_0000);
    repeat (2) @(posedge core_clk);
    chk({26'h0, sc.div}, 32'h03);
    wr(off_run_clock_config, 32'h0180_09c0);
    repeat (2) @(posedge core_clk);
    chk({30'h0, sc.use_pll, sc.div_en}, 32'h0);
    wr(off_run_clock_config, 32'h01c0_09c0);
    mosc_tick <= 1'b1;
    do
      @(posedge core_clk);
    while (irq !== 1'b1);
    mosc_tick <= 1'b0;
    rd(off_raw_irq_status, 32'h40);
    chk({31'h0, sc.use_pll}, 32'h0);
    wr(off_run_clock_config, cfg_b);
    repeat (3) @(posedge core_clk);
    chk({31'h0, sc.use_pll}, 32'h1);
  endtask
  task report_and_stop;
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop;
  end
  initial
  begin
    {resetn, cyc, stb, we, mosc_tick, wfi, ds_en, wake} = '0;
    adr = '0;
    sel = 4'hf;
    wdat = '0;
    n_fail = 0;
    samples_checked = 0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_reset;
    t_lock;
    t_sleep;
    t_deep;
    report_and_stop;
  end
endmodule
bind pll_clock_and_sleep_gating clk_ctrl_chk #(.lock_count_w(lock_count_w))
  i_clk_ctrl_chk (.core_clk(core_clk), .resetn(resetn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .mosc_tick(mosc_tick), .wfi_req(wfi_req), .deep_sleep_en(deep_sleep_en),
  .wake_irq(wake_irq), .pll_power_down(pll_power_down),
  .pll_translation(pll_translation), .sys_clk(sys_clk),
  .core_clk_en(core_clk_en), .iosc_power_up(iosc_power_up),
  .mosc_power_down(mosc_power_down));
`default_nettype wire
